// [rtl/cmd_decoder_pkg.sv]
// What this block does
// R01: every transaction opens with a command byte; first byte after idle is the command
// R02: command byte picks the one register and direction of the next data phase
// R03: bit 7 must be zero; a transaction starts only when it is low
// R04: bit 6 selects direction: 0 write, 1 read
// R05: bits 5:0 are the six-bit target register address
// R06: fixed addresses: status, modes, checksum, data, gpio, id
// R07: 0x10-0x1f channels 0-15; 0x30-0x3f offsets 0-7 then gains 0-7
// R08: 0x20-0x27 setup configuration registers 0-7
// R09: 0x28-0x2f filter configuration registers 0-7
// R10: command register at 0x00, write-only, resets to 0x00
// R11: a read of address zero returns the status register, reset 0x80
// R12: after the data phase, wait for a new command; unassigned addresses ignored
package cmd_decoder_pkg;

    localparam logic [5:0] CMD_REG_OFFSET = 6'h00;
    localparam logic [7:0] CMD_RESET = 8'h00;
    localparam logic [7:0] STATUS_RESET = 8'h80;
    localparam int START_BIT = 7;
    localparam int DIR_BIT = 6;
    localparam int ADDR_HI = 5;
    localparam int ADDR_LO = 0;
    localparam int CHAN_SEL_LO = 4;
    localparam int CHAN_IDX_HI = 3;
    localparam int BANK_SEL_LO = 3;
    localparam int BANK_IDX_HI = 2;
    localparam logic [5:0] ADDR_STATUS = 6'h00;
    localparam logic [5:0] ADDR_ADC_MODE = 6'h01;
    localparam logic [5:0] ADDR_IF_MODE = 6'h02;
    localparam logic [5:0] ADDR_CHECKSUM = 6'h03;
    localparam logic [5:0] ADDR_DATA = 6'h04;
    localparam logic [5:0] ADDR_GPIO = 6'h06;
    localparam logic [5:0] ADDR_ID = 6'h07;
    localparam logic [1:0] GRP_CHANNEL = 2'h1;
    localparam logic [2:0] GRP_SETUP = 3'h4;
    localparam logic [2:0] GRP_FILTER = 3'h5;
    localparam logic [2:0] GRP_OFFSET = 3'h6;
    localparam logic [2:0] GRP_GAIN = 3'h7;

    typedef enum logic [3:0] {
        TGT_NONE = 4'h0,
        TGT_STATUS = 4'h1,
        TGT_ADC_MODE = 4'h2,
        TGT_IF_MODE = 4'h3,
        TGT_CHECKSUM = 4'h4,
        TGT_DATA = 4'h5,
        TGT_GPIO = 4'h6,
        TGT_ID = 4'h7,
        TGT_CHANNEL = 4'h8,
        TGT_SETUP = 4'h9,
        TGT_FILTER = 4'ha,
        TGT_OFFSET = 4'hb,
        TGT_GAIN = 4'hc
    } target_kind_t;

    typedef struct packed {
        logic valid;
        logic read;
        logic [5:0] target_register_address;
        target_kind_t kind;
        logic [3:0] index;
    } decoded_cmd_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_DATA = 2'b01
    } phase_state_t;

endpackage

// [rtl/address_map_decode.sv]
`timescale 1ns/1ps
`default_nettype none
module address_map_decode
    import cmd_decoder_pkg::*;
(
    // address in
    input wire logic [5:0] addr_i,
    // decoded target
    output target_kind_t kind_o,
    output logic [3:0] index_o
);
    always_comb begin
        kind_o = TGT_NONE;
        index_o = 4'h0;
        case (addr_i)
            ADDR_STATUS: kind_o = TGT_STATUS; // R06
            ADDR_ADC_MODE: kind_o = TGT_ADC_MODE; // R06
            ADDR_IF_MODE: kind_o = TGT_IF_MODE;
            ADDR_CHECKSUM: kind_o = TGT_CHECKSUM;
            ADDR_DATA: kind_o = TGT_DATA;
            ADDR_GPIO: kind_o = TGT_GPIO;
            ADDR_ID: kind_o = TGT_ID;
            default: begin
                if (addr_i[ADDR_HI:CHAN_SEL_LO] == GRP_CHANNEL) begin
                    kind_o = TGT_CHANNEL; // R07
                    index_o = addr_i[CHAN_IDX_HI:ADDR_LO];
                end else if (addr_i[ADDR_HI:BANK_SEL_LO] == GRP_SETUP) begin
                    kind_o = TGT_SETUP; // R08
                    index_o = {1'b0, addr_i[BANK_IDX_HI:ADDR_LO]};
                end else if (addr_i[ADDR_HI:BANK_SEL_LO] == GRP_FILTER) begin
                    kind_o = TGT_FILTER; // R09
                    index_o = {1'b0, addr_i[BANK_IDX_HI:ADDR_LO]};
                end else if (addr_i[ADDR_HI:BANK_SEL_LO] == GRP_OFFSET) begin
                    kind_o = TGT_OFFSET; // R07
                    index_o = {1'b0, addr_i[BANK_IDX_HI:ADDR_LO]};
                end else if (addr_i[ADDR_HI:BANK_SEL_LO] == GRP_GAIN) begin
                    kind_o = TGT_GAIN; // R07
                    index_o = {1'b0, addr_i[BANK_IDX_HI:ADDR_LO]};
                end
            end
        endcase
    end
endmodule // address_map_decode
`default_nettype wire

// [rtl/adc_serial_command_decoder.sv]
`timescale 1ns/1ps
`default_nettype none
module adc_serial_command_decoder
(
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // incoming bytes from the serial shifter
    input wire logic byte_valid_i,
    input wire logic [7:0] byte_i,
    // end of the data phase, from the data-phase engine
    input wire logic phase_done_i,
    // status value from the converter core
    input wire logic [7:0] status_i,
    // decoded command
    output cmd_decoder_pkg::decoded_cmd_t cmd_o,
    output logic cmd_strobe_o,
    output logic busy_o,
    output logic [7:0] command_register_o,
    output logic [7:0] read_data_o
);
    import cmd_decoder_pkg::*;

    // a byte opens a transaction only while idle and with the start bit low
    function automatic logic opens_transaction(
        input phase_state_t state,
        input logic valid,
        input logic [7:0] b
    );
        return (state == ST_IDLE) && valid && !b[START_BIT]; // R01 R03
    endfunction

    // addresses without a register never start a data phase
    // 0x05 and 0x08-0x0f have no register behind them
    function automatic logic has_register(
        input target_kind_t k
    );
        return k != TGT_NONE; // R12
    endfunction

    // address zero snapshots the status register only when read; a write to it still decodes as TGT_STATUS
    function automatic logic names_status(
        input logic [7:0] b
    );
        return b[DIR_BIT] && (b[ADDR_HI:ADDR_LO] == CMD_REG_OFFSET); // R11
    endfunction

    // phase sequencing
    phase_state_t state_q;
    phase_state_t state_d;

    // captured command
    logic [7:0] command_register_q;
    logic [7:0] command_register_d;
    decoded_cmd_t cmd_q;
    decoded_cmd_t cmd_d;

    // acceptance pulse
    logic strobe_q;
    logic strobe_d;

    // status snapshot
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;

    // data phase in progress
    logic busy_q;
    logic busy_d;

    // decode of the byte now on the input
    target_kind_t kind;
    logic [3:0] index;

    // qualified events
    logic take_byte;
    logic take_cmd;
    logic status_read;
    logic end_phase;

    address_map_decode u_map (
        .addr_i(byte_i[ADDR_HI:ADDR_LO]),
        .kind_o(kind),
        .index_o(index)
    );

    // qualifiers shared by the groups below, except busy, which works from state_d
    always_comb begin
        // a byte with bit 7 set is dropped whole; the host must send it again
        take_byte = opens_transaction(state_q, byte_valid_i, byte_i);
        take_cmd = take_byte && has_register(kind);
        status_read = take_byte && names_status(byte_i);
        // bytes during the data phase belong to it, never to a new command
        end_phase = (state_q == ST_DATA) && phase_done_i;
    end

    // phase sequencing
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                // unassigned address: no data phase follows
                if (take_cmd) begin
                    state_d = ST_DATA; // R02
                end
            end
            ST_DATA: begin
                if (end_phase) begin
                    state_d = ST_IDLE; // R12
                end
            end
            default: begin
                // unused code: fall back to waiting for a command
                state_d = ST_IDLE;
            end
        endcase
    end

    // reset leaves the block waiting for a command byte
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // command capture
    always_comb begin
        command_register_d = command_register_q;
        cmd_d = cmd_q;
        case (state_q)
            ST_IDLE: begin
                if (take_byte) begin
                    command_register_d = byte_i; // R10
                    cmd_d.read = byte_i[DIR_BIT]; // R04
                    cmd_d.target_register_address = byte_i[ADDR_HI:ADDR_LO]; // R05
                    cmd_d.kind = kind; // R02
                    cmd_d.index = index;
                    // unassigned address: fields kept for debug, valid stays low
                    cmd_d.valid = has_register(kind); // R12
                end
            end
            ST_DATA: begin
                // the data-phase engine owns the port until it reports the end
                if (end_phase) begin
                    cmd_d.valid = 1'b0; // R12
                end
            end
            default: begin
                cmd_d.valid = 1'b0;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            command_register_q <= CMD_RESET; // R10
            cmd_q <= '0;
        end else begin
            command_register_q <= command_register_d;
            cmd_q <= cmd_d;
        end
    end

    // one pulse per command that has a register behind it
    // a command to a hole gives no pulse, so no data-phase engine starts
    always_comb begin
        strobe_d = 1'b0;
        if (take_cmd) begin
            strobe_d = 1'b1; // R02
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            strobe_q <= 1'b0;
        end else begin
            strobe_q <= strobe_d;
        end
    end

    // status snapshot, held until the next read of address zero
    // status_i is taken as it stands; the core must keep it steady that cycle
    always_comb begin
        rdata_d = rdata_q;
        if (status_read) begin // R11
            rdata_d = status_i;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            rdata_q <= STATUS_RESET; // R11
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // from the next state, so busy rises together with the strobe
    always_comb begin
        busy_d = 1'b0;
        if (state_d == ST_DATA) begin
            busy_d = 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            busy_q <= 1'b0;
        end else begin
            busy_q <= busy_d;
        end
    end

    // every output comes straight from a register
    assign cmd_o = cmd_q;
    assign cmd_strobe_o = strobe_q;
    assign busy_o = busy_q;
    assign command_register_o = command_register_q;
    assign read_data_o = rdata_q;
endmodule // adc_serial_command_decoder
`default_nettype wire

// [sim/host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module host_model (
    // clock and data-phase handshake
    input wire logic ref_clk_i,
    input wire logic busy_i,
    output logic phase_done_o
);
    int wait_q = 0;
    // data phase ends after a random 0 to 4 cycles, prompt or slow
    always @(negedge ref_clk_i) begin
        phase_done_o <= 1'b0;
        if (!busy_i) begin
            wait_q <= $urandom_range(4);
        end else if (wait_q == 0) begin
            phase_done_o <= 1'b1;
        end else begin
            wait_q <= wait_q - 1;
        end
    end
endmodule // host_model
`default_nettype wire

// [sim/cmd_decoder_checker.sv]
`timescale 1ns/1ps
`default_nettype none
module cmd_decoder_checker
    import cmd_decoder_pkg::*;
(
    // dut ports
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic byte_valid_i,
    input wire logic [7:0] byte_i,
    input wire logic phase_done_i,
    input wire logic [7:0] status_i,
    input wire decoded_cmd_t cmd_o,
    input wire logic cmd_strobe_o,
    input wire logic busy_o,
    input wire logic [7:0] command_register_o,
    input wire logic [7:0] read_data_o
);
    logic cand;
    logic hole;
    assign cand = byte_valid_i && !busy_o && !byte_i[7];
    assign hole = byte_i[5:3] == 3'h1 || byte_i[5:0] == 6'h05;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    property p_take; cand && !hole |=> cmd_strobe_o && busy_o && cmd_o.valid; endproperty
    a_take: assert property (p_take) else $error("command not taken");
    property p_ign; byte_valid_i && byte_i[7] && !busy_o |=> !cmd_strobe_o && !busy_o; endproperty
    a_ign: assert property (p_ign) else $error("start bit high accepted");
    property p_dir; cmd_strobe_o |-> cmd_o.read == $past(byte_i[6]); endproperty
    a_dir: assert property (p_dir) else $error("direction wrong");
    property p_addr; cmd_strobe_o |-> cmd_o.target_register_address == $past(byte_i[5:0]);
    endproperty
    a_addr: assert property (p_addr) else $error("address wrong");
    property p_hold; busy_o && !phase_done_i |=> busy_o && !cmd_strobe_o && $stable(cmd_o);
    endproperty
    a_hold: assert property (p_hold) else $error("data phase disturbed");
    property p_end; busy_o && phase_done_i |=> !busy_o && !cmd_o.valid; endproperty
    a_end: assert property (p_end) else $error("phase did not end");
    property p_hole; cand && hole |=> !cmd_strobe_o && !busy_o; endproperty
    a_hole: assert property (p_hole) else $error("unassigned address started");
    property p_creg; cmd_strobe_o |-> command_register_o == $past(byte_i); endproperty
    a_creg: assert property (p_creg) else $error("command register wrong");
    property p_stat; cmd_strobe_o && cmd_o.read && cmd_o.target_register_address == 6'h00
        |-> read_data_o == $past(status_i); endproperty
    a_stat: assert property (p_stat) else $error("status not captured");
    c_read: cover property (cand && byte_i[6]);
    c_done: cover property (busy_o && phase_done_i);
    c_start: cover property (byte_valid_i && byte_i[7]);
endmodule // cmd_decoder_checker
bind adc_serial_command_decoder cmd_decoder_checker chk (.*);
`default_nettype wire

// [sim/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin fails++; \
    $display("[ERR] %0t %h %h", $time, a, b); end end
module tb_top;
    import cmd_decoder_pkg::*;
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic byte_valid_i = 1'b0;
    logic [7:0] byte_i = 8'h00;
    logic phase_done_i;
    logic [7:0] status_i = 8'h00;
    decoded_cmd_t cmd_o;
    logic cmd_strobe_o;
    logic busy_o;
    logic [7:0] command_register_o;
    logic [7:0] read_data_o;
    int fails = 0;
    int checks_done = 0;
    always #10 ref_clk_i = ~ref_clk_i;
    adc_serial_command_decoder dut (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .byte_valid_i(byte_valid_i),
        .byte_i(byte_i),
        .phase_done_i(phase_done_i),
        .status_i(status_i),
        .cmd_o(cmd_o),
        .cmd_strobe_o(cmd_strobe_o),
        .busy_o(busy_o),
        .command_register_o(command_register_o),
        .read_data_o(read_data_o)
    );
    host_model host (.ref_clk_i(ref_clk_i), .busy_i(busy_o), .phase_done_o(phase_done_i));
    function automatic logic [7:0] exp_k(input logic [5:0] a);
        if (a[5]) return {4'h9 + {2'b00, a[4:3]}, 1'b0, a[2:0]};
        if (a[4]) return {4'h8, a[3:0]};
        if (a[3] || a == 6'h05) return 8'h00;
        if (a == 6'h06) return {TGT_GPIO, 4'h0};
        if (a == 6'h07) return {TGT_ID, 4'h0};
        return {a[3:0] + 4'h1, 4'h0};
    endfunction
    task automatic cmd(input logic [7:0] b);
        logic [7:0] k;
        logic [7:0] st;
        logic [7:0] cr;
        logic ok;
        k = exp_k(b[5:0]);
        ok = !b[7] && k != 8'h00;
        st = read_data_o;
        cr = command_register_o;
        status_i = 8'($urandom);
        if (ok && b[6] && b[5:0] == 6'h00) st = status_i;
        @(negedge ref_clk_i);
        byte_valid_i = 1'b1;
        byte_i = b;
        @(negedge ref_clk_i);
        `CHK(cmd_strobe_o, ok)
        `CHK(busy_o, ok)
        `CHK(read_data_o, st)
        `CHK(command_register_o, b[7] ? cr : b)
        if (ok) begin
            `CHK(cmd_o, {1'b1, b[6:0], k})
            // valid stays high: this byte lands in the data phase and must be ignored
            byte_i = 8'($urandom_range(127));
            @(negedge ref_clk_i);
        end else begin
            `CHK(cmd_o.valid, 1'b0)
        end
        byte_valid_i = 1'b0;
        byte_i = ~b;
        `CHK(cmd_strobe_o, 1'b0)
        for (int i = 0; i < 20 && busy_o; i++) @(negedge ref_clk_i);
        `CHK(busy_o, 1'b0)
        `CHK(cmd_o.valid, 1'b0)
    endtask
    task complete_run;
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        void'($urandom(32'hca05));
        repeat (2) @(negedge ref_clk_i);
        rst_i = 1'b0;
        `CHK(cmd_o, 16'h0000)
        `CHK(command_register_o, 8'h00)
        `CHK(read_data_o, 8'h80)
        `CHK(cmd_strobe_o, 1'b0)
        `CHK(busy_o, 1'b0)
        $display("test reset done");
        for (int a = 0; a < 64; a++) cmd({1'b0, 1'($urandom), 6'(a)});
        $display("test map done");
        repeat (60) cmd(8'($urandom));
        $display("test random done");
        complete_run;
    end
    initial begin
        #200000;
        fails++;
        complete_run;
    end
endmodule // tb_top
`default_nettype wire
